// ==== hw/mfr_consts.svh ====
// Constants of the tone receiver card port logic: widths, offsets, fields,
// reset values and timing figures. Included by the package and the top module.
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define MFR_PORTS          8
`define MFR_PORT_IDX_W     3
`define MFR_SLOT_W         8
`define MFR_DIGIT_W        4
`define MFR_CARD_ADDR_W    8
`define MFR_CPU_ADDR_W     16
`define MFR_CPU_DATA_W     8
`define MFR_LED_W          3

// ----------------------------------------------------------------------------
// Processor address map
// ----------------------------------------------------------------------------
`define MFR_STAT_BASE      16'h0000
`define MFR_STAT_LAST      16'h0007
`define MFR_LED_ADDR       16'h0010
`define MFR_SLOT_BASE      16'h0020
`define MFR_SLOT_LAST      16'h0027
`define MFR_BUSSEL_ADDR    16'h0030

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MFR_STAT_VALID_BIT 7
`define MFR_LED_RED_BIT    0
`define MFR_LED_YEL_BIT    1
`define MFR_LED_GRN_BIT    2

// ----------------------------------------------------------------------------
// Digit codes seen on the detector inputs and in the status words
// ----------------------------------------------------------------------------
`define MFR_DIG_NONE       4'h0
`define MFR_DIG_ZERO       4'hA
`define MFR_DIG_KP         4'hB
`define MFR_DIG_ST         4'hC
`define MFR_DIG_STP        4'hD
`define MFR_DIG_STP2       4'hE
`define MFR_DIG_STP3       4'hF

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MFR_LED_RST        3'h0
`define MFR_QUIET_SLOT     8'h00
`define MFR_BUSSEL_RST     8'h00
`define MFR_STAT_RST       8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MFR_CLK_HZ         64'd125000000
`define MFR_TONE_MIN_MS    64'd40
`define MFR_MS_PER_S       64'd1000
`define MFR_QUAL_CYC       ((`MFR_TONE_MIN_MS * `MFR_CLK_HZ + `MFR_MS_PER_S - 64'd1) / `MFR_MS_PER_S)
`define MFR_CODEC_LO_HZ    64'd1544000
`define MFR_CODEC_HI_HZ    64'd2048000
`define MFR_NCO_W          32
`define MFR_NCO_INC(f)     ((f << `MFR_NCO_W) / `MFR_CLK_HZ)

`endif

// ==== hw/mfr_pkg.sv ====
// Types shared by the tone receiver card port logic.
// Assumes mfr_consts.svh is on the include path.
package mfr_pkg;
  `include "mfr_consts.svh"

  // Per-port digit qualifier state
  typedef enum logic [1:0] {
    DET_QUIET_OK,
    DET_TONE_QUAL,
    DET_TONE_ON,
    DET_QUIET_QUAL
  } mfr_det_e;

  // Poll scanner state
  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_RUN,
    SCAN_END
  } mfr_scan_e;

  // One time slot on both PCM data buses
  typedef struct packed {
    logic [`MFR_SLOT_W-1:0] slot;
    logic [`MFR_SLOT_W-1:0] data_a;
    logic [`MFR_SLOT_W-1:0] data_b;
  } mfr_pcm_s;

  // One status change report to the bus controller
  typedef struct packed {
    logic                                        end_mark;
    logic [`MFR_CARD_ADDR_W+`MFR_PORT_IDX_W-1:0] port_addr;
    logic [`MFR_DIGIT_W-1:0]                     digit;
  } mfr_rpt_s;
endpackage

// ==== hw/mfr_pair_buf.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; head is oldest entry.
`timescale 1ns/1ps
module mfr_pair_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  input  wire logic         out_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data
);
  logic [1:0]   count;
  logic [W-1:0] tail;
  logic         push;
  logic         pop;

  // Handshakes
  assign in_ready = (count != 2'd2);
  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;

  // Entry count and output valid
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count     <= 2'd0;
      out_valid <= 1'b0;
    end else begin
      count     <= count + {1'b0, push} - {1'b0, pop};
      out_valid <= (count + {1'b0, push} - {1'b0, pop}) != 2'd0;
    end
  end

  // Data movement
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      out_data <= '0;
      tail     <= '0;
    end else if (pop) begin
      if (push && count == 2'd1) begin
        out_data <= in_data;
      end else begin
        out_data <= tail;
        if (push) begin
          tail <= in_data;
        end
      end
    end else if (push) begin
      if (count == 2'd0) begin
        out_data <= in_data;
      end else begin
        tail <= in_data;
      end
    end
  end
endmodule

// ==== hw/mfr_port_logic.sv ====
// Port logic of the eight-port tone receiver card: slot capture, digit
// qualification, status words, poll reports, LEDs, codec jumpers.
// Assumes all inputs synchronous to ref_clk; detector hybrids drive tone inputs.
//
// Summary of operation
// RULE1 - Every port captures any slot from either PCM bus independently.
// RULE2 - Slot and bus per port come from its configured slot and bus select.
// RULE3 - Controller reassigns an unused port to a quiet slot.
// RULE4 - Card takes eight consecutive port addresses from its slot position.
// RULE5 - Status reports one of fifteen digits: 0-9, KP, ST, STP, STP2, STP3.
// RULE6 - Port status is read at addresses 0000 to 0007 in port order.
// RULE7 - Three LEDs follow a writable register; zero lights, one darkens.
// RULE8 - Firmware lights red, yellow, green for major, minor, standby.
// RULE9 - On a poll the card reports status changes since the last report.
// RULE10 - Companding jumper picks mu-law at U, A-law at A; mu-law default.
// RULE11 - Codec clock jumper picks 1.544 or 2.048 MHz; 1.544 default.
// RULE12 - Digit needs 40 ms of tone, and 40 ms of quiet between digits.
// RULE13 - Status holds valid flag and digit; set on detection, cleared on read.
// RULE14 - Reset selects quiet slots, clears status, lights all LEDs.
`timescale 1ns/1ps
`include "mfr_consts.svh"
module mfr_port_logic
  import mfr_pkg::*;
#(
  parameter int QUAL_CYCLES = int'(`MFR_QUAL_CYC)
) (
  // Clock and reset
  input  wire logic                                           ref_clk,
  input  wire logic                                           rstn,
  // Card slot position and jumpers
  input  wire logic [`MFR_CARD_ADDR_W-1:0]                    card_addr,
  input  wire logic                                           companding_select_jumper,
  input  wire logic                                           codec_clock_jumper,
  // PCM time slot buses
  input  wire logic                                           pcm_strobe,
  input  wire mfr_pcm_s                                       pcm_in,
  // Codec side, one sample per port
  output logic [`MFR_PORTS-1:0]                               codec_load,
  output logic [`MFR_PORTS-1:0][`MFR_SLOT_W-1:0]              codec_data,
  output logic                                                codec_alaw,
  output logic                                                codec_clk,
  // Receiver hybrid outputs
  input  wire logic [`MFR_PORTS-1:0]                          tone_present,
  input  wire logic [`MFR_PORTS-1:0][`MFR_DIGIT_W-1:0]        tone_digit,
  // Card processor memory bus
  input  wire logic [`MFR_CPU_ADDR_W-1:0]                     cpu_addr,
  input  wire logic                                           cpu_rd,
  input  wire logic                                           cpu_wr,
  input  wire logic [`MFR_CPU_DATA_W-1:0]                     cpu_wdata,
  output logic [`MFR_CPU_DATA_W-1:0]                          cpu_rdata,
  // Poll and reports to the central bus controller
  input  wire logic                                           poll_req,
  input  wire logic                                           rpt_ready,
  output logic                                                rpt_valid,
  output mfr_rpt_s                                            rpt_data,
  // Card address block and front panel
  output logic [`MFR_CARD_ADDR_W-1:0]                         port_base,
  output logic                                                led_red_n,
  output logic                                                led_yellow_n,
  output logic                                                led_green_n
);
  localparam int CW = $clog2(QUAL_CYCLES + 1);
  localparam logic [CW-1:0] QUAL_LAST = CW'(QUAL_CYCLES - 1);
  localparam logic [`MFR_NCO_W-1:0] INC_LO = `MFR_NCO_W'(`MFR_NCO_INC(`MFR_CODEC_LO_HZ));
  localparam logic [`MFR_NCO_W-1:0] INC_HI = `MFR_NCO_W'(`MFR_NCO_INC(`MFR_CODEC_HI_HZ));

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [`MFR_PORTS-1:0][`MFR_SLOT_W-1:0]  cfg_slot;
  logic [`MFR_PORTS-1:0]                   cfg_bus_b;
  logic [`MFR_LED_W-1:0]                   led_reg;
  mfr_det_e                                det_state [`MFR_PORTS];
  logic [CW-1:0]                           det_cnt   [`MFR_PORTS];
  logic [`MFR_PORTS-1:0][`MFR_DIGIT_W-1:0] det_cand;
  logic [`MFR_PORTS-1:0]                   det_evt;
  logic [`MFR_PORTS-1:0]                   stat_valid;
  logic [`MFR_PORTS-1:0][`MFR_DIGIT_W-1:0] stat_digit;
  logic [`MFR_PORTS-1:0]                   pending;
  logic                                    base_taken;
  logic [`MFR_NCO_W-1:0]                   nco_acc;
  mfr_scan_e                               scan_state;
  logic [`MFR_PORT_IDX_W-1:0]              scan_idx;
  logic                                    buf_in_valid;
  logic                                    buf_in_ready;
  mfr_rpt_s                                buf_in_data;
  logic                                    scan_take;
  logic                                    stat_rd;
  logic [`MFR_PORT_IDX_W-1:0]              rd_port;

  // True when an address falls in the status port range
  function automatic logic is_stat(input logic [`MFR_CPU_ADDR_W-1:0] a);
    return (a - `MFR_STAT_BASE) <= (`MFR_STAT_LAST - `MFR_STAT_BASE);
  endfunction

  // Digit code carried by a hybrid output: zero means no digit
  function automatic logic is_digit(input logic [`MFR_DIGIT_W-1:0] d);
    return d != `MFR_DIG_NONE;
  endfunction

  assign stat_rd = cpu_rd && is_stat(cpu_addr);
  assign rd_port = cpu_addr[`MFR_PORT_IDX_W-1:0];

  // ---------------------------------------------------------------------------
  // Processor writes: LEDs, slot and bus selection
  // ---------------------------------------------------------------------------
  // LED register, zero lights an LED
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      led_reg <= `MFR_LED_RST; // RULE14
    end else if (cpu_wr && cpu_addr == `MFR_LED_ADDR) begin
      led_reg <= cpu_wdata[`MFR_LED_W-1:0]; // RULE7
    end
  end

  // LED pins follow the register bit for bit
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      led_red_n    <= 1'b0;
      led_yellow_n <= 1'b0;
      led_green_n  <= 1'b0;
    end else begin
      led_red_n    <= led_reg[`MFR_LED_RED_BIT]; // RULE7
      led_yellow_n <= led_reg[`MFR_LED_YEL_BIT];
      led_green_n  <= led_reg[`MFR_LED_GRN_BIT];
    end
  end

  // Per-port slot and bus selection
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_slot  <= {`MFR_PORTS{`MFR_QUIET_SLOT}}; // RULE14
      cfg_bus_b <= `MFR_BUSSEL_RST;
    end else if (cpu_wr) begin
      if (cpu_addr >= `MFR_SLOT_BASE && cpu_addr <= `MFR_SLOT_LAST) begin
        cfg_slot[cpu_addr[`MFR_PORT_IDX_W-1:0]] <= cpu_wdata; // RULE2
      end
      if (cpu_addr == `MFR_BUSSEL_ADDR) begin
        cfg_bus_b <= cpu_wdata; // RULE2
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Slot capture
  // ---------------------------------------------------------------------------
  // Each port compares the passing slot with its own choice
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      codec_load <= '0;
      codec_data <= '0;
    end else begin
      for (int p = 0; p < `MFR_PORTS; p++) begin
        codec_load[p] <= pcm_strobe && (pcm_in.slot == cfg_slot[p]); // RULE1
        if (pcm_strobe && pcm_in.slot == cfg_slot[p]) begin
          codec_data[p] <= cfg_bus_b[p] ? pcm_in.data_b : pcm_in.data_a; // RULE2
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Jumpers and codec clock
  // ---------------------------------------------------------------------------
  // Companding law, low is mu-law
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      codec_alaw <= 1'b0;
    end else begin
      codec_alaw <= companding_select_jumper; // RULE10
    end
  end

  // Phase accumulator making the chosen codec clock
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      nco_acc   <= '0;
      codec_clk <= 1'b0;
    end else begin
      nco_acc   <= nco_acc + (codec_clock_jumper ? INC_HI : INC_LO); // RULE11
      codec_clk <= nco_acc[`MFR_NCO_W-1];
    end
  end

  // Card address block caught once after reset release
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      base_taken <= 1'b0;
      port_base  <= '0;
    end else if (!base_taken) begin
      base_taken <= 1'b1;
      port_base  <= card_addr; // RULE4
    end
  end

  // ---------------------------------------------------------------------------
  // Digit qualification
  // ---------------------------------------------------------------------------
  // Tone and quiet must each hold for the full qualifying time
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      det_evt  <= '0;
      det_cand <= '0;
      for (int p = 0; p < `MFR_PORTS; p++) begin
        det_state[p] <= DET_QUIET_OK;
        det_cnt[p]   <= '0;
      end
    end else begin
      det_evt <= '0;
      for (int p = 0; p < `MFR_PORTS; p++) begin
        unique case (det_state[p])
          DET_QUIET_OK: begin
            if (tone_present[p] && is_digit(tone_digit[p])) begin
              det_state[p] <= DET_TONE_QUAL;
              det_cand[p]  <= tone_digit[p];
              det_cnt[p]   <= '0;
            end
          end
          DET_TONE_QUAL: begin
            if (!tone_present[p] || tone_digit[p] != det_cand[p]) begin
              det_state[p] <= DET_QUIET_QUAL; // RULE12
              det_cnt[p]   <= '0;
            end else if (det_cnt[p] == QUAL_LAST) begin
              det_state[p] <= DET_TONE_ON; // RULE12
              det_evt[p]   <= 1'b1;
            end else begin
              det_cnt[p] <= det_cnt[p] + 1'b1;
            end
          end
          DET_TONE_ON: begin
            if (!tone_present[p]) begin
              det_state[p] <= DET_QUIET_QUAL;
              det_cnt[p]   <= '0;
            end
          end
          DET_QUIET_QUAL: begin
            if (tone_present[p]) begin
              det_cnt[p] <= '0; // RULE12
            end else if (det_cnt[p] == QUAL_LAST) begin
              det_state[p] <= DET_QUIET_OK; // RULE12
            end else begin
              det_cnt[p] <= det_cnt[p] + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status words and processor reads
  // ---------------------------------------------------------------------------
  // Valid flag set by a detection, cleared by a read; set wins
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stat_valid <= '0; // RULE14
      stat_digit <= '0;
    end else begin
      for (int p = 0; p < `MFR_PORTS; p++) begin
        if (det_evt[p]) begin
          stat_valid[p] <= 1'b1; // RULE13
          stat_digit[p] <= det_cand[p]; // RULE5
        end else if (stat_rd && rd_port == p[`MFR_PORT_IDX_W-1:0]) begin
          stat_valid[p] <= 1'b0; // RULE13
        end
      end
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cpu_rdata <= `MFR_STAT_RST;
    end else if (cpu_rd) begin
      if (is_stat(cpu_addr)) begin
        cpu_rdata <= {stat_valid[rd_port], 3'h0, stat_digit[rd_port]}; // RULE6
      end else if (cpu_addr == `MFR_LED_ADDR) begin
        cpu_rdata <= {5'h00, led_reg};
      end else if (cpu_addr >= `MFR_SLOT_BASE && cpu_addr <= `MFR_SLOT_LAST) begin
        cpu_rdata <= cfg_slot[rd_port];
      end else if (cpu_addr == `MFR_BUSSEL_ADDR) begin
        cpu_rdata <= cfg_bus_b;
      end else begin
        cpu_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Poll scanner and report buffer
  // ---------------------------------------------------------------------------
  assign scan_take    = (scan_state == SCAN_RUN) && pending[scan_idx] && buf_in_ready;
  assign buf_in_valid = ((scan_state == SCAN_RUN) && pending[scan_idx]) || (scan_state == SCAN_END);

  // Report word: port entry or end marker
  always_comb begin
    buf_in_data           = '0;
    buf_in_data.end_mark  = (scan_state == SCAN_END);
    buf_in_data.port_addr = {port_base, scan_idx}; // RULE4
    buf_in_data.digit     = stat_digit[scan_idx];
  end

  // Changes not yet reported; a new detection outlives the report
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pending <= '0;
    end else begin
      for (int p = 0; p < `MFR_PORTS; p++) begin
        if (det_evt[p]) begin
          pending[p] <= 1'b1; // RULE9
        end else if (scan_take && scan_idx == p[`MFR_PORT_IDX_W-1:0]) begin
          pending[p] <= 1'b0;
        end
      end
    end
  end

  // Walk all ports on a poll, then close with an end marker
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      scan_state <= SCAN_IDLE;
      scan_idx   <= '0;
    end else begin
      unique case (scan_state)
        SCAN_IDLE: begin
          if (poll_req) begin
            scan_state <= SCAN_RUN; // RULE9
            scan_idx   <= '0;
          end
        end
        SCAN_RUN: begin
          if (!pending[scan_idx] || buf_in_ready) begin
            scan_idx <= scan_idx + 1'b1;
            if (scan_idx == `MFR_PORT_IDX_W'(`MFR_PORTS - 1)) begin
              scan_state <= SCAN_END;
            end
          end
        end
        SCAN_END: begin
          if (buf_in_ready) begin
            scan_state <= SCAN_IDLE;
          end
        end
        default: begin
          scan_state <= SCAN_IDLE;
        end
      endcase
    end
  end

  // Report buffer toward the bus controller
  mfr_pair_buf #(
    .W ($bits(mfr_rpt_s))
  ) u_rpt_buf (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_ready (rpt_ready),
    .out_valid (rpt_valid),
    .out_data  (rpt_data)
  );
endmodule

// ==== verification/mfr_port_props.sv ====
// Assertions on the ports of the tone receiver card port logic.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
module mfr_port_props
  import mfr_pkg::*;
#(
  parameter int QUAL_CYCLES = 8
) (
  // Clock, reset, straps
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [7:0]  card_addr,
  input wire logic        companding_select_jumper,
  // PCM and codec
  input wire logic        pcm_strobe,
  input wire logic [7:0]  codec_load,
  input wire logic        codec_alaw,
  // Processor bus and panel
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_rd,
  input wire logic        cpu_wr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_rdata,
  input wire logic        led_red_n,
  input wire logic [7:0]  port_base,
  // Reports
  input wire logic        rpt_ready,
  input wire logic        rpt_valid,
  input wire mfr_rpt_s    rpt_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // LED register write, then pin two edges on
  sequence led_wr_s;
    cpu_wr && cpu_addr == 16'h0010;
  endsequence
  sequence stat_rd_s;
    cpu_rd && cpu_addr <= 16'h0007;
  endsequence
  led_follow_a: assert property (led_wr_s |-> ##2 led_red_n == $past(cpu_wdata[0], 2)) else $error("LED pin wrong");
  stat_form_a: assert property (stat_rd_s |=> cpu_rdata[6:4] == 3'h0) else $error("Status word form");
  unmapped_zero_a: assert property (cpu_rd && cpu_addr == 16'h0100 |=> cpu_rdata == 8'h00) else $error("Unmapped read");
  rpt_hold_a: assert property (rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_data)) else $error("Report dropped");
  rpt_addr_a: assert property (rpt_valid && !rpt_data.end_mark |-> rpt_data.port_addr[10:3] == port_base) else $error("Report address");
  alaw_follow_a: assert property ($past(rstn) |-> codec_alaw == $past(companding_select_jumper)) else $error("Law select");
  base_latch_a: assert property ($rose(rstn) |=> port_base == $past(card_addr)) else $error("Port base");
  load_cause_a: assert property (|codec_load |-> $past(pcm_strobe)) else $error("Load without strobe");
endmodule
bind mfr_port_logic mfr_port_props #(.QUAL_CYCLES(QUAL_CYCLES)) i_mfr_port_props (
  .ref_clk(ref_clk), .rstn(rstn), .card_addr(card_addr), .companding_select_jumper(companding_select_jumper),
  .pcm_strobe(pcm_strobe), .codec_load(codec_load), .codec_alaw(codec_alaw), .cpu_addr(cpu_addr),
  .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .led_red_n(led_red_n),
  .port_base(port_base), .rpt_ready(rpt_ready), .rpt_valid(rpt_valid), .rpt_data(rpt_data));

// ==== verification/mfr_ctl_model.sv ====
// Central bus controller model: takes report words, stalls on request.
// Assumes the card's ref_clk and rstn.
`timescale 1ns/1ps
module mfr_ctl_model
  import mfr_pkg::*;
(
  // Clock and reset
  input wire logic     ref_clk,
  input wire logic     rstn,
  // Stall mode from the bench
  input wire logic     slow,
  // Report stream
  input wire logic     rpt_valid,
  input wire mfr_rpt_s rpt_data,
  output logic         rpt_ready
);
  mfr_rpt_s   seen[$];
  logic [1:0] tick;
  // Collect words; ready one cycle in four when slow
  always_ff @(posedge ref_clk) begin
    tick <= rstn ? tick + 2'h1 : 2'h0;
    if (rpt_valid && rpt_ready) seen.push_back(rpt_data);
  end
  assign rpt_ready = !slow || tick == 2'h3;
endmodule

// ==== verification/mfr_port_logic_test.sv ====
// Self-checking bench of the tone receiver card port logic.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
module mfr_port_logic_test;
  import mfr_pkg::*;
  typedef struct packed {logic wr; logic [15:0] a; logic [7:0] d;} mfr_row_s;
  localparam int QC = 8;
  logic ref_clk = 0, rstn = 0, alaw_j = 0, clk_j = 0, pcm_strobe = 0;
  logic cpu_rd = 0, cpu_wr = 0, poll_req = 0, slow = 0, rpt_ready, rpt_valid, codec_alaw, codec_clk;
  logic [7:0] card_addr = 8'h5A, cpu_wdata = 0, codec_load, cpu_rdata, port_base, tone_present = 0;
  logic [15:0] cpu_addr = 0;
  logic [7:0][7:0] codec_data;
  logic [7:0][3:0] tone_digit = 0;
  logic r_n, y_n, g_n;
  mfr_pcm_s pcm_in = 0;
  mfr_rpt_s rpt_data;
  int bad_count = 0, samples_checked = 0;
  mfr_row_s rows [9] = '{'{1, 16'h0010, 8'h05}, '{0, 16'h0010, 8'h05}, '{1, 16'h0025, 8'h7F},
    '{0, 16'h0025, 8'h7F}, '{1, 16'h0030, 8'hA4}, '{0, 16'h0030, 8'hA4}, '{1, 16'h0003, 8'hFF},
    '{0, 16'h0003, 8'h00}, '{0, 16'h0100, 8'h00}};
  mfr_port_logic #(.QUAL_CYCLES(QC)) i_mfr_port_logic (.ref_clk(ref_clk), .rstn(rstn),
    .card_addr(card_addr), .companding_select_jumper(alaw_j), .codec_clock_jumper(clk_j),
    .pcm_strobe(pcm_strobe), .pcm_in(pcm_in), .codec_load(codec_load), .codec_data(codec_data),
    .codec_alaw(codec_alaw), .codec_clk(codec_clk), .tone_present(tone_present), .tone_digit(tone_digit),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .poll_req(poll_req), .rpt_ready(rpt_ready), .rpt_valid(rpt_valid), .rpt_data(rpt_data),
    .port_base(port_base), .led_red_n(r_n), .led_yellow_n(y_n), .led_green_n(g_n));
  mfr_ctl_model i_mfr_ctl_model (.ref_clk(ref_clk), .rstn(rstn), .slow(slow), .rpt_valid(rpt_valid),
    .rpt_data(rpt_data), .rpt_ready(rpt_ready));
  // 125 MHz clock and hang limit
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // One processor cycle, strobe held across one rising edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = wr;
    cpu_rd = !wr;
    @(negedge ref_clk);
    cpu_wr = 0;
    cpu_rd = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    check({8'h00, cpu_rdata}, {8'h00, e});
  endtask
  // Hold one tone on a port, then quiet
  task automatic tone(input int p, input logic [3:0] d, input int n);
    @(negedge ref_clk);
    tone_present[p] = 1;
    tone_digit[p] = d;
    repeat (n) @(negedge ref_clk);
    tone_present[p] = 0;
    repeat (QC + 4) @(negedge ref_clk);
  endtask
  // Rising codec clock edges over 1000 cycles
  task automatic clk_edges(output int n);
    logic last;
    n = 0;
    last = codec_clk;
    repeat (1000) begin
      @(negedge ref_clk);
      n += int'(codec_clk && !last);
      last = codec_clk;
    end
  endtask
  task automatic poll(input int n);
    int k;
    @(negedge ref_clk);
    poll_req = 1;
    @(negedge ref_clk);
    poll_req = 0;
    for (k = 0; k < 300 && i_mfr_ctl_model.seen.size() < n; k++) @(negedge ref_clk);
    if (k == 300) begin
      bad_count++;
      test_done();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    repeat (4) @(negedge ref_clk);
    rstn = 1;
    for (int p = 0; p < 8; p++) rd(p[15:0], 8'h00);
    check({13'h0000, r_n, y_n, g_n}, 16'h0000);
    check({8'h00, port_base}, 16'h005A);
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) check({8'h00, cpu_rdata}, {8'h00, rows[i].d});
    end
    @(negedge ref_clk);
    check({13'h0000, r_n, y_n, g_n}, 16'h0005);
    clk_edges(n);
    check({15'h0000, (n inside {[12:13]})}, 16'h0001);
    acc(1, 16'h0010, 8'h06);
    acc(1, 16'h0025, 8'h00);
    acc(1, 16'h0022, 8'h05);
    acc(1, 16'h0023, 8'h05);
    acc(1, 16'h0030, 8'h04);
    alaw_j = 1;
    clk_j = 1;
    pcm_in = '{8'h05, 8'h11, 8'h22};
    pcm_strobe = 1;
    @(negedge ref_clk);
    pcm_strobe = 0;
    check({8'h00, codec_load}, 16'h000C);
    check({8'h00, codec_data[2]}, 16'h0022);
    check({8'h00, codec_data[3]}, 16'h0011);
    check({15'h0000, codec_alaw}, 16'h0001);
    clk_edges(n);
    check({15'h0000, (n inside {[16:17]})}, 16'h0001);
    acc(1, 16'h0022, 8'h00);
    acc(1, 16'h0023, 8'h00);
    for (int d = 1; d < 16; d++) begin
      tone(0, d[3:0], QC + 4);
      rd(16'h0000, {4'h8, d[3:0]});
    end
    rd(16'h0000, 8'h0F);
    tone(1, 4'h5, QC - 4);
    rd(16'h0001, 8'h00);
    slow = 1;
    poll(2);
    check(i_mfr_ctl_model.seen[0], {1'b0, 8'h5A, 3'h0, 4'hF});
    check({15'h0000, i_mfr_ctl_model.seen[1].end_mark}, 16'h0001);
    poll(3);
    check({15'h0000, i_mfr_ctl_model.seen[2].end_mark}, 16'h0001);
    test_done();
  end
endmodule
